/* common/dsg_pkg.sv */
// Shared constants, types and helpers of the strobe-group datapath.
package dsg_pkg;

	// Supported data lines per strobe, and group counts in total and per die edge.
	localparam int GRP_X8             = 8;
	localparam int GRP_X16            = 16;
	localparam int GRP_X32            = 32;
	localparam int X8_GROUPS          = 20;
	localparam int X8_GROUPS_PER_EDGE = 10;
	localparam int X16_GROUPS         = 8;
	localparam int X16_GROUPS_PER_EDGE = 4;
	localparam int X32_GROUPS_PER_EDGE = 2;

	// Timing of the system clock and of the incoming strobe.
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int LINK_PERIOD_PS = 64000;
	localparam int SHIFT72_DEG    = 72;
	localparam int SHIFT90_DEG    = 90;
	localparam int FULL_DEG       = 360;
	// Longest delays round down so capture never lands past the eye centre.
	localparam int SHIFT72_CYC = (LINK_PERIOD_PS * SHIFT72_DEG) / (FULL_DEG * CLK_PERIOD_PS);
	localparam int SHIFT90_CYC = (LINK_PERIOD_PS * SHIFT90_DEG) / (FULL_DEG * CLK_PERIOD_PS);
	localparam int SHIFT_PIPE  = SHIFT90_CYC;

	// System cycles per quarter of the generated memory clock.
	localparam int CK_QUARTER_CYC = 4;

	// Reset values.
	// Phase starts in the last quarter so the first clock pulse after reset is a full one.
	localparam logic [1:0] PHASE_RST = 2'h3;
	localparam logic       DM_IDLE   = 1'h1;

	// Strobe phase shift; Gray coded along 0, 72, 90 degrees.
	typedef enum logic [1:0] {
		DSG_SHIFT_0  = 2'h0,
		DSG_SHIFT_72 = 2'h1,
		DSG_SHIFT_90 = 2'h3
	} dsg_shift_e;

	// Smallest supported group that holds the requested lines.
	function automatic int dsg_group_fit(input int lines);
		if (lines <= GRP_X8) begin
			return GRP_X8;
		end
		if (lines <= GRP_X16) begin
			return GRP_X16;
		end
		return GRP_X32;
	endfunction : dsg_group_fit

endpackage : dsg_pkg

/* common/dsg_buf_if.sv */
// Valid/ready carrier between the write path and its two-entry buffer.
`timescale 1ns/1ps
interface dsg_buf_if #(parameter int W = 9);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;

	modport buffer (input in_valid, input in_data, input out_ready,
		output in_ready, output out_valid, output out_data);
	modport user (output in_valid, output in_data, output out_ready,
		input in_ready, input out_valid, input out_data);
endinterface : dsg_buf_if

/* hw/dsg_pair_buffer.sv */
// Two-entry buffer that absorbs a stall of the pin serialiser.
`timescale 1ns/1ps
module dsg_pair_buffer
	import dsg_pkg::*;
#(
	parameter int W = 9
) (
	input  wire logic clk_sys,
	input  wire logic rst_n_sync,
	dsg_buf_if.buffer bus
);
	logic [W-1:0] mem_reg [2];
	logic         wr_ptr_reg;
	logic         rd_ptr_reg;
	logic [1:0]   count_reg;
	logic [1:0]   count_next;
	logic         ready_reg;
	wire          push = bus.in_valid & ready_reg;
	wire          pop  = bus.out_valid & bus.out_ready;

	assign count_next    = count_reg + {1'h0, push} - {1'h0, pop};
	assign bus.in_ready  = ready_reg;
	assign bus.out_valid = (count_reg != 2'h0);
	assign bus.out_data  = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			wr_ptr_reg <= 1'h0;
			rd_ptr_reg <= 1'h0;
			count_reg  <= 2'h0;
			ready_reg  <= 1'h1;
		end else begin
			wr_ptr_reg <= wr_ptr_reg ^ push;
			rd_ptr_reg <= rd_ptr_reg ^ pop;
			count_reg  <= count_next;
			ready_reg  <= (count_next != 2'h2);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= bus.in_data;
		end
	end

	full_stall_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		count_reg == 2'h2 |-> !ready_reg)
		else $error("Buffer full but still ready.");
	stall_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		bus.out_valid && !bus.out_ready |=> bus.out_valid && $stable(bus.out_data))
		else $error("Buffered word lost during a stall.");
	buf_full_c: cover property (@(posedge clk_sys) disable iff (!rst_n_sync)
		count_reg == 2'h2);

endmodule : dsg_pair_buffer

/* hw/dsg_strobe_group.sv */
// One strobe group: write serialiser, memory clock and strobe-timed read capture.
// How it works
// R01: Data lines are served by one strobe in groups of 8, 16 or 32.
// R02: Odd widths take the next larger group; surplus lines stay undriven.
// R03: Eight-line mode allows 20 groups, ten per top and bottom edge.
// R04: Sixteen-line mode allows eight groups, four per top and bottom edge.
// R05: The strobe pin is either a bidirectional strobe or a read-only read clock.
// R06: Input-only data and strobe pins keep their output enables low.
// R07: Mask low writes the word, mask high tells memory to drop it.
// R08: Each group has its own mask output, idle during reads.
// R09: Mask leaves the same early-quarter output register as write data.
// R10: Check bits ride with the data; encoded on write, checked on read.
// R11: A high read-valid flag means the memory is returning read data.
// R12: The read-valid flag leads the first data word by half a clock.
// R13: Memory clock pins come from output registers, not the clock tree.
// R14: Each incoming strobe is delayed by 0, 72 or 90 degrees before capture.
// R15: On side banks the read strobe is ignored; own clock times capture.
// R16: Read data is captured on both strobe edges, two words per cycle.
`timescale 1ns/1ps
module dsg_strobe_group
	import dsg_pkg::*;
#(
	parameter int DATA_W       = 8,
	parameter int CHECK_W      = 1,
	parameter int CK_DIV       = CK_QUARTER_CYC,
	parameter bit STROBE_BIDIR = 1'b1,
	parameter bit INPUT_ONLY   = 1'b0,
	parameter bit USE_FLAG     = 1'b1,
	parameter int GROUP_SLOT   = 0
) (
	input  wire logic                            clk_sys,
	input  wire logic                            rst_b,
	input  wire logic                            wr_valid,
	input  wire logic [DATA_W-1:0]               wr_data,
	input  wire logic                            wr_mask,
	output logic                                 wr_ready,
	input  wire logic                            rd_arm,
	input  wire dsg_shift_e                      shift_sel,
	input  wire logic                            side_bank,
	output logic                                 rd_valid,
	output logic                                 rd_falling,
	output logic [DATA_W-1:0]                    rd_data,
	output logic                                 rd_check_err,
	input  wire logic [dsg_group_fit(DATA_W+CHECK_W)-1:0] dq_in,
	output logic [dsg_group_fit(DATA_W+CHECK_W)-1:0] dq_out,
	output logic [dsg_group_fit(DATA_W+CHECK_W)-1:0] dq_oe,
	input  wire logic                            strobe_in,
	output logic                                 strobe_out,
	output logic                                 strobe_oe,
	output logic                                 dm_out,
	input  wire logic                            read_valid_flag,
	output logic                                 mem_ck,
	output logic                                 mem_ck_n
);
	localparam int LANE_W  = DATA_W + CHECK_W;
	localparam int GROUP_W = dsg_group_fit(LANE_W); // R01 R02
	localparam int HALF_CK = 2 * CK_DIV;
	localparam int DIV_W   = $clog2(CK_DIV + 1);
	localparam int HIGH_W  = $clog2(HALF_CK + 1);

	// Check bit k is the parity of every data bit whose index is k modulo CHECK_W.
	function automatic logic [CHECK_W-1:0] check_of(input logic [DATA_W-1:0] d);
		logic [CHECK_W-1:0] c;
		c = '0;
		for (int i = 0; i < DATA_W; i++) begin
			c[i % CHECK_W] = c[i % CHECK_W] ^ d[i];
		end
		return c;
	endfunction : check_of

	logic              rst_s1_reg;
	logic              rst_n_sync;
	logic [DIV_W-1:0]  div_reg;
	logic [1:0]        phase_reg;
	logic              ck_reg;
	logic              drive_reg;
	logic [LANE_W-1:0] lane_reg;
	logic              dm_reg;
	logic              stb_s1_reg;
	logic              stb_s2_reg;
	logic              stb_s3_reg;
	logic [GROUP_W-1:0] dq_s1_reg;
	logic [GROUP_W-1:0] dq_s2_reg;
	logic              flag_s1_reg;
	logic              flag_s2_reg;
	logic [SHIFT_PIPE-1:0] edge_pipe_reg;
	logic              flag_prev_reg;
	logic              rd_valid_reg;
	logic              rd_falling_reg;
	logic [DATA_W-1:0] rd_data_reg;
	logic              rd_err_reg;
	logic [HIGH_W-1:0] ck_high_reg;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'h0;
			rst_n_sync <= 1'h0;
		end else begin
			rst_s1_reg <= 1'h1;
			rst_n_sync <= rst_s1_reg;
		end
	end

	// Write path: the user word plus its check bits and mask goes through the buffer.
	dsg_buf_if #(.W(LANE_W + 1)) wbuf ();
	assign wbuf.in_valid = wr_valid;
	assign wbuf.in_data  = {wr_mask, check_of(wr_data), wr_data}; // R10
	assign wr_ready      = wbuf.in_ready;

	dsg_pair_buffer #(.W(LANE_W + 1)) u_wbuf (
		.clk_sys    (clk_sys),
		.rst_n_sync (rst_n_sync),
		.bus        (wbuf)
	);

	// Quarter-period tick; the clock is high in phases 0 and 1.
	wire       tick       = (div_reg == DIV_W'(CK_DIV - 1));
	wire [1:0] phase_next = phase_reg + 2'h1;
	// Data and mask move one quarter ahead of each clock edge (odd phases).
	wire       data_slot  = tick & phase_next[0];
	wire       ck_edge    = tick & ~phase_next[0];
	wire       take_word  = data_slot & wbuf.out_valid & ~INPUT_ONLY;
	assign wbuf.out_ready = data_slot & ~INPUT_ONLY;

	always_ff @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			div_reg   <= '0;
			phase_reg <= PHASE_RST;
			ck_reg    <= 1'h0;
		end else begin
			div_reg <= tick ? '0 : div_reg + DIV_W'(1);
			if (tick) begin
				phase_reg <= phase_next;
				ck_reg    <= ~phase_next[1]; // R13
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			drive_reg <= 1'h0;
			lane_reg  <= '0;
			dm_reg    <= DM_IDLE;
		end else if (data_slot) begin
			drive_reg <= take_word;
			lane_reg  <= wbuf.out_data[LANE_W-1:0];
			// An empty slot leaves the mask high so the memory writes nothing.
			dm_reg    <= take_word ? wbuf.out_data[LANE_W] : DM_IDLE; // R07 R08 R09
		end
	end

	assign mem_ck     = ck_reg;
	assign mem_ck_n   = ~ck_reg;
	assign dm_out     = dm_reg;
	assign dq_out     = GROUP_W'(lane_reg);
	assign dq_oe      = GROUP_W'({LANE_W{drive_reg}}); // R02 R06
	assign strobe_out = ck_reg;
	assign strobe_oe  = drive_reg & STROBE_BIDIR; // R05 R06

	// Read path: every pin from the memory passes two flip-flops first.
	always_ff @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			// The strobe idles high, so no false edge follows the release of reset.
			stb_s1_reg  <= 1'h1;
			stb_s2_reg  <= 1'h1;
			stb_s3_reg  <= 1'h1;
			dq_s1_reg   <= '0;
			dq_s2_reg   <= '0;
			flag_s1_reg <= 1'h0;
			flag_s2_reg <= 1'h0;
		end else begin
			stb_s1_reg  <= strobe_in;
			stb_s2_reg  <= stb_s1_reg;
			stb_s3_reg  <= stb_s2_reg;
			dq_s1_reg   <= dq_in;
			dq_s2_reg   <= dq_s1_reg;
			flag_s1_reg <= read_valid_flag;
			flag_s2_reg <= flag_s1_reg;
		end
	end

	wire stb_edge = stb_s2_reg ^ stb_s3_reg; // R16
	wire shifted_edge = (shift_sel == DSG_SHIFT_0)  ? stb_edge :
	                    (shift_sel == DSG_SHIFT_72) ? edge_pipe_reg[SHIFT72_CYC-1] :
	                                                  edge_pipe_reg[SHIFT90_CYC-1]; // R14
	// Side banks have no strobe delay circuit, so the own clock edges time capture.
	wire cap_pulse = side_bank ? ck_edge : shifted_edge; // R15
	// The flag leads data by half a clock: a word counts when the flag stood at the edge before.
	wire cap_ok    = USE_FLAG ? flag_prev_reg : rd_arm; // R11 R12
	wire [LANE_W-1:0] cap_lane = dq_s2_reg[LANE_W-1:0];

	always_ff @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			edge_pipe_reg  <= '0;
			flag_prev_reg  <= 1'h0;
			rd_valid_reg   <= 1'h0;
			rd_falling_reg <= 1'h0;
			rd_data_reg    <= '0;
			rd_err_reg     <= 1'h0;
		end else begin
			edge_pipe_reg <= {edge_pipe_reg[SHIFT_PIPE-2:0], stb_edge};
			rd_valid_reg  <= cap_pulse & cap_ok;
			if (cap_pulse) begin
				flag_prev_reg <= flag_s2_reg;
			end
			if (cap_pulse & cap_ok) begin
				rd_falling_reg <= side_bank ? phase_next[1] : ~stb_s2_reg; // R16
				rd_data_reg    <= cap_lane[DATA_W-1:0];
				rd_err_reg     <= (check_of(cap_lane[DATA_W-1:0]) != cap_lane[LANE_W-1:DATA_W]); // R10
			end
		end
	end

	assign rd_valid     = rd_valid_reg;
	assign rd_falling   = rd_falling_reg;
	assign rd_data      = rd_data_reg;
	assign rd_check_err = rd_err_reg;

	// Counts the high phase of the memory clock so its check needs no long repetition.
	always_ff @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			ck_high_reg <= '0;
		end else begin
			ck_high_reg <= ck_reg ? ck_high_reg + HIGH_W'(1) : '0;
		end
	end

	group_size_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		GROUP_W >= LANE_W && (GROUP_W == GRP_X8 || GROUP_W == GRP_X16 || GROUP_W == GRP_X32)) // R01
		else $error("Group width is not a supported size.");
	slot_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		(GROUP_W == GRP_X8 && GROUP_SLOT < X8_GROUPS_PER_EDGE) ||
		(GROUP_W == GRP_X16 && GROUP_SLOT < X16_GROUPS_PER_EDGE) ||
		(GROUP_W == GRP_X32 && GROUP_SLOT < X32_GROUPS_PER_EDGE)) // R03 R04
		else $error("Group slot beyond the edge's group count.");
	ck_half_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		$fell(mem_ck) |-> ck_high_reg == HIGH_W'(HALF_CK)) // R13
		else $error("Memory clock high phase has the wrong length.");
	dm_lead_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		$changed(dm_out) |-> ##CK_DIV $changed(mem_ck)) // R09
		else $error("Mask does not lead the clock edge by a quarter.");
	dm_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		dq_oe == '0 |-> dm_out) // R07 R08
		else $error("Mask low while no write data is driven.");
	oe_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		(strobe_oe || dq_oe != '0) |-> !INPUT_ONLY && strobe_oe == (STROBE_BIDIR && dq_oe[0])) // R05 R06
		else $error("Output enable raised on an input-only pin.");
	spare_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		(dq_oe >> LANE_W) == '0) // R02
		else $error("Surplus data line driven.");
	shift90_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		!side_bank && shift_sel == DSG_SHIFT_90 && $stable(shift_sel) && stb_edge
		&& cap_ok |-> ##SHIFT90_CYC ##1 rd_valid || $changed(shift_sel)) // R14
		else $error("Strobe capture delay is not the 90 degree count.");
	flag_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		USE_FLAG && rd_valid |-> $past(flag_prev_reg)) // R11 R12
		else $error("Read word taken without the valid flag.");
	side_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n_sync)
		side_bank && $past(side_bank) && rd_valid |-> $past(ck_edge)) // R15
		else $error("Side-bank capture followed the strobe.");

	wr_word_c: cover property (@(posedge clk_sys) disable iff (!rst_n_sync)
		take_word && !wbuf.out_data[LANE_W]);
	rd_pair_c: cover property (@(posedge clk_sys) disable iff (!rst_n_sync)
		rd_valid && !rd_falling ##[1:20] rd_valid && rd_falling);
	side_rd_c: cover property (@(posedge clk_sys) disable iff (!rst_n_sync)
		side_bank && rd_valid);
	ecc_err_c: cover property (@(posedge clk_sys) disable iff (!rst_n_sync)
		rd_valid && rd_check_err);

endmodule : dsg_strobe_group

/* sim/dsg_mem_model.sv */
// Behavioural memory device on the far side of one strobe group.
`timescale 1ns/1ps
module dsg_mem_model (
	input  wire logic        mem_ck,
	input  wire logic [15:0] dq_pin,
	input  wire logic [15:0] dq_oe,
	input  wire logic        dm_out,
	output logic             strobe_drv,
	output logic [15:0]      dq_drv,
	output logic             read_valid_flag
);
	logic [31:0] wr_q[$];
	bit          in_frame;

	initial begin
		strobe_drv = 1'b1;
		dq_drv = 16'h0000;
		read_valid_flag = 1'b0;
	end

	// Released data lines keep no value, so they toggle outside frames.
	always #7 if (!in_frame) dq_drv = ~dq_drv;

	// Words whose mask is high are dropped; only unmasked ones are stored.
	always @(mem_ck) if (dq_oe[0] === 1'b1 && dm_out === 1'b0) wr_q.push_back({dq_oe, 7'h00, dq_pin[8:0]});

	// The read clock stands high between frames and runs at 64 ns inside them.
	task automatic burst(input logic [31:0] d, input bit flag, input bit bad);
		logic [15:0] w;
		in_frame = 1'b1;
		#1.7;
		strobe_drv = 1'b0;
		read_valid_flag = flag;
		for (int k = 0; k < 4; k++) begin
			#32;
			w[7:0] = d[8*k +: 8];
			w[8] = ^w[7:0] ^ bad;
			w[15:9] = 7'h2a;
			strobe_drv = ~strobe_drv;
			dq_drv = w;
			if (k == 3) read_valid_flag = 1'b0;
		end
		#32;
		strobe_drv = 1'b1;
		dq_drv = ~dq_drv;
		#32;
		in_frame = 1'b0;
	endtask : burst
endmodule : dsg_mem_model

/* sim/dsg_strobe_group_tb.sv */
// Self-checking bench of one strobe group against a behavioural memory.
`timescale 1ns/1ps
module dsg_strobe_group_tb;
	import dsg_pkg::*;
	logic        clk_sys, rst_b, wr_valid, wr_mask, wr_ready;
	logic        rd_valid, rd_falling, rd_check_err, dm_out, flag, mem_ck, mem_ck_n;
	logic        strobe_out, strobe_oe, strobe_drv, strobe_pin, side_bank;
	logic [7:0]  wr_data, rd_data;
	logic [15:0] dq_out, dq_oe, dq_drv, dq_pin;
	dsg_shift_e  shift_sel;
	int          mismatches, total_checks;
	logic [9:0]  rd_q[$];
	bit          stalled, strobe_on, strobe_bad;

	assign dq_pin = (dq_out & dq_oe) | (dq_drv & ~dq_oe);
	assign strobe_pin = strobe_oe ? strobe_out : strobe_drv;

	dsg_strobe_group dsg_strobe_group_i (.clk_sys(clk_sys), .rst_b(rst_b), .wr_valid(wr_valid),
		.wr_data(wr_data), .wr_mask(wr_mask), .wr_ready(wr_ready), .rd_arm(1'b0),
		.shift_sel(shift_sel), .side_bank(side_bank), .rd_valid(rd_valid), .rd_falling(rd_falling),
		.rd_data(rd_data), .rd_check_err(rd_check_err), .dq_in(dq_pin), .dq_out(dq_out),
		.dq_oe(dq_oe), .strobe_in(strobe_pin), .strobe_out(strobe_out), .strobe_oe(strobe_oe),
		.dm_out(dm_out), .read_valid_flag(flag), .mem_ck(mem_ck), .mem_ck_n(mem_ck_n));
	dsg_mem_model dsg_mem_model_i (.mem_ck(mem_ck), .dq_pin(dq_pin), .dq_oe(dq_oe),
		.dm_out(dm_out), .strobe_drv(strobe_drv), .dq_drv(dq_drv), .read_valid_flag(flag));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(negedge clk_sys) if (rd_valid === 1'b1) rd_q.push_back({rd_falling, rd_check_err, rd_data});

	// The write strobe must follow the memory clock exactly while data is driven.
	always @(negedge clk_sys) begin
		if (strobe_oe === 1'b1) strobe_on = 1'b1;
		if (strobe_oe !== (dq_oe[0] === 1'b1) || mem_ck_n !== ~mem_ck) strobe_bad = 1'b1;
		if (strobe_oe === 1'b1 && strobe_out !== mem_ck) strobe_bad = 1'b1;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	task automatic test_reset();
		chk("mem_ck_pair", 32'h2, {mem_ck_n, mem_ck});
		chk("dm_out", 32'h1, dm_out);
		chk("dq_oe", 32'h0, dq_oe);
		chk("rd_valid", 32'h0, rd_valid);
	endtask : test_reset

	// Request held from one rising edge until the edge where ready is high.
	task automatic send_word(input logic [7:0] d, input logic m);
		wr_valid <= 1'b1;
		wr_data <= d;
		wr_mask <= m;
		for (int i = 0; i < 40; i++) begin
			@(negedge clk_sys);
			if (wr_ready === 1'b1) break;
			stalled = 1'b1;
		end
		chk("wr_ready", 32'h1, wr_ready);
		@(posedge clk_sys);
	endtask : send_word

	task automatic test_write();
		logic [7:0] d[5] = '{8'ha5, 8'h3c, 8'hff, 8'h00, 8'h81};
		int         j;
		j = 0;
		@(posedge clk_sys);
		for (int k = 0; k < 5; k++) send_word(d[k], k == 1);
		wr_valid <= 1'b0;
		repeat (60) @(posedge clk_sys);
		chk("wr_stall", 32'h1, stalled);
		chk("strobe_on", 32'h1, strobe_on);
		chk("strobe_pair", 32'h0, strobe_bad);
		chk("strobe_idle", 32'h0, strobe_oe);
		chk("wr_count", 32'h4, dsg_mem_model_i.wr_q.size());
		for (int k = 0; k < 5; k++) begin
			if (k != 1 && j < dsg_mem_model_i.wr_q.size()) begin
				chk("wr_word", {16'h01ff, 7'h00, ^d[k], d[k]}, dsg_mem_model_i.wr_q[j]);
				j++;
			end
		end
	endtask : test_write

	task automatic read_burst(input logic [31:0] d, input bit fl, input bit bad, input int n);
		rd_q.delete();
		dsg_mem_model_i.burst(d, fl, bad);
		repeat (10) @(posedge clk_sys);
		chk("rd_count", n, rd_q.size());
		for (int k = 0; k < n && k < rd_q.size(); k++) begin
			chk("rd_word", {22'h0, k[0], bad, d[8*k +: 8]}, rd_q[k]);
		end
	endtask : read_burst

	task automatic test_read_shifts();
		dsg_shift_e s[3] = '{DSG_SHIFT_0, DSG_SHIFT_72, DSG_SHIFT_90};
		for (int i = 0; i < 3; i++) begin
			shift_sel <= s[i];
			@(posedge clk_sys);
			read_burst(32'h5ac30ff0 ^ 32'(i), 1'b1, 1'b0, 4);
		end
	endtask : test_read_shifts

	task automatic test_read_noflag();
		read_burst(32'h12345678, 1'b0, 1'b0, 0);
	endtask : test_read_noflag

	task automatic test_read_badcheck();
		read_burst(32'h96e1c33c, 1'b1, 1'b1, 4);
	endtask : test_read_badcheck

	// Side banks time capture by the memory clock: 3 or 4 of its edges fall in the flag window.
	task automatic test_read_side();
		side_bank <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd_q.delete();
		dsg_mem_model_i.burst(32'hc3a55a3c, 1'b1, 1'b0);
		repeat (10) @(posedge clk_sys);
		chk("side_count", 32'h1, 32'(rd_q.size() inside {3, 4}));
		side_bank <= 1'b0;
		@(posedge clk_sys);
	endtask : test_read_side

	initial begin
		rst_b = 1'b0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		wr_mask = 1'b0;
		shift_sel = DSG_SHIFT_0;
		side_bank = 1'b0;
		repeat (5) @(posedge clk_sys);
		test_reset();
		@(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
		test_write();
		test_read_shifts();
		test_read_noflag();
		test_read_badcheck();
		test_read_side();
		final_report();
	end

	// The whole sequence needs about 2 us; ten times that means a hang.
	initial begin
		#20000;
		mismatches++;
		final_report();
	end
endmodule : dsg_strobe_group_tb
